// file: design/rcma_pkg.sv
// Purpose: constants for the run-command mode arbiter
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes:   offsets are byte addresses
package rcma_pkg;
  // --------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------
  localparam logic [7:0] RCMA_CFG_OFS    = 8'h00;
  localparam logic [7:0] RCMA_IN_OFS     = 8'h04;
  localparam logic [7:0] RCMA_STAT_OFS   = 8'h08;
  localparam logic [7:0] RCMA_CTRL_OFS   = 8'h0c;
  // --------------------------------------------------------------
  // configuration fields
  // --------------------------------------------------------------
  localparam int CFG_SRC_LSB    = 0;   // command source, 3 bits
  localparam int CFG_KEYF_LSB   = 4;   // mode-toggle key function, 2 bits
  localparam int CFG_PREV_LSB   = 8;   // direction prevention, 2 bits
  localparam int CFG_PONR_BIT   = 12;  // power-on run
  localparam int CFG_SS_LSB     = 16;  // speed-search options, 8 bits
  localparam int SS_START_BIT   = 4;   // speed search at start
  localparam int CFG_EN_LSB     = 24;  // run-enable terminal mask, 7 bits
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  // --------------------------------------------------------------
  // input register fields (software view of keypad and terminals)
  // --------------------------------------------------------------
  localparam int IN_RUNKEY_BIT  = 0;
  localparam int IN_STOPKEY_BIT = 1;
  localparam int IN_REVKEY_BIT  = 2;
  localparam int IN_JOG_BIT     = 3;
  // --------------------------------------------------------------
  // control fields
  // --------------------------------------------------------------
  localparam int CTRL_FRST_BIT  = 0;   // fault reset occurred during run
  localparam int CTRL_COMM_BIT  = 1;   // run command from digital link
  localparam int CTRL_CDIR_BIT  = 2;   // digital link direction
  // --------------------------------------------------------------
  // encodings
  // --------------------------------------------------------------
  localparam logic [2:0] SRC_KEYPAD  = 3'h0;
  localparam logic [2:0] SRC_FWDREV  = 3'h1;  // terminal_fwd_rev_mode
  localparam logic [2:0] SRC_RUNDIR  = 3'h2;  // terminal_run_dir_mode
  localparam logic [2:0] SRC_MAX     = 3'h5;
  localparam logic [1:0] KEYF_LOCREM = 2'h2;
  localparam logic [1:0] PREV_NONE   = 2'h0;
  localparam logic [1:0] PREV_FWD    = 2'h1;
  localparam logic [1:0] PREV_REV    = 2'h2;
  localparam logic [1:0] AXI_OKAY    = 2'h0;
  localparam logic [1:0] AXI_SLVERR  = 2'h2;
  typedef enum logic [1:0] {RCMA_STOP, RCMA_SEARCH, RCMA_RUN, RCMA_DECEL} rcma_state_t;
endpackage

// file: design/rcma_arbiter.sv
// Purpose: local/remote run-command arbitration with direction prevention and power-on run
// Assumes: one 40 MHz clock, synchronous active-low reset standing for power-on
// Notes:   terminals and keys pass a three-flop filter; registers over AXI4-Lite
//
// Summary of operation
// - key function 2 lets mode-toggle key presses switch local and remote
// - assigning the local/remote function forces remote mode immediately
// - local to remote switch leaves all configuration values unchanged
// - toggle in remote selects local, flashes set light, keypad run only
// - toggle in local selects remote, set light off, follow command source
// - local jog only while an input configured as run-enable is on
// - remote takes run and direction from the configured command source
// - power-on run off: terminal commands wait until all released, reasserted
// - fault reset powers up local; later remote stops, waits for release
// - remote to local while running stops the output
// - remote with terminal source keeps running; reverse input forces reverse
// - remote with keypad or link source stops, waits next run command
// - prevention 0 none, 1 blocks forward, 2 blocks reverse
// - reverse key with prevention 2 decelerates to zero and stops
// - power-on run allowed only with terminal sources 1 or 2
// - power-on run 1 starts at power-up if terminal run inputs on
// - speed-search option bit 4 searches speed before driving motor
// - without search start normal pattern; power-on run off needs re-press
// - command source takes values 0 to 5
// - run/direction mode: forward input runs, reverse input selects direction
`timescale 1ns/100ps
module rcma_arbiter #(
  parameter int N_IN    = 7,
  parameter int BLINK_W = 23   // flash period about 0.2 s at 40 MHz
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             mode_toggle_key,
  input  wire logic [N_IN-1:0]  multi_function_inputs,
  input  wire logic             forward_run_input,
  input  wire logic             reverse_run_input,
  input  wire logic             preexcite_input,
  input  wire logic             at_zero_speed,
  input  wire logic             search_done,
  output logic                  set_led,
  output logic                  remote_mode,
  output logic                  run_out,
  output logic                  dir_rev,
  output logic                  search_out,
  output logic                  decel_out,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);
  if (N_IN < 1 || N_IN > 7) begin : g_chk
    $error("N_IN must be 1 to 7");
  end
  if (BLINK_W < 2 || BLINK_W > 31) begin : g_chk_blink
    $error("BLINK_W must be 2 to 31");
  end
  localparam int NP = N_IN + 4;
  // edges after reset release before the filtered pins can be trusted
  localparam logic [2:0] FLT_LAT = 3'h4;

  // --------------------------------------------------------------
  // pin filter: three flops, change taken when the last two agree
  // --------------------------------------------------------------
  logic [NP-1:0] pin_raw, s1_r, s2_r, s3_r, pin_r;
  assign pin_raw = {preexcite_input, reverse_run_input, forward_run_input,
                    mode_toggle_key, multi_function_inputs};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      pin_r <= '0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < NP; i++) begin
        if (s2_r[i] == s3_r[i]) pin_r[i] <= s3_r[i];
      end
    end
  end
  logic [N_IN-1:0] mfi;
  logic key_f, fx_f, rx_f, pex_f, key_d_r;
  assign mfi   = pin_r[N_IN-1:0];
  assign key_f = pin_r[N_IN];
  assign fx_f  = pin_r[N_IN+1];
  assign rx_f  = pin_r[N_IN+2];
  assign pex_f = pin_r[N_IN+3];

  // the filter starts all-low, so a pin held on through reset reads off at first;
  // arming waits until the filter has caught up
  logic [2:0] prime_r;
  logic       primed;
  assign primed = prime_r == FLT_LAT;
  always_ff @(posedge aclk) begin
    if (!aresetn) prime_r <= 3'h0;
    else if (!primed) prime_r <= prime_r + 3'h1;
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  logic [31:0] cfg_r, in_r, ctrl_r;
  logic [2:0]  src;
  logic [1:0]  keyf, prev;
  logic        ponr, ss_en;
  logic [N_IN-1:0] en_mask;
  assign src     = cfg_r[rcma_pkg::CFG_SRC_LSB +: 3];
  assign keyf    = cfg_r[rcma_pkg::CFG_KEYF_LSB +: 2];
  assign prev    = cfg_r[rcma_pkg::CFG_PREV_LSB +: 2];
  assign ponr    = cfg_r[rcma_pkg::CFG_PONR_BIT];
  assign ss_en   = cfg_r[rcma_pkg::CFG_SS_LSB + rcma_pkg::SS_START_BIT];
  assign en_mask = cfg_r[rcma_pkg::CFG_EN_LSB +: N_IN];

  logic aw_r, w_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_go, wr_cfg, keyf_set;
  logic [31:0] cfg_new;
  assign wr_go = aw_r && w_r && !s_axi_bvalid;
  always_comb begin
    cfg_new = cfg_r;
    for (int b = 0; b < 4; b++) begin
      if (wstrb_r[b]) cfg_new[8*b +: 8] = wdata_r[8*b +: 8];
    end
  end
  // source values above 5 are refused and leave the register alone
  assign wr_cfg   = wr_go && awaddr_r == rcma_pkg::RCMA_CFG_OFS
                    && cfg_new[rcma_pkg::CFG_SRC_LSB +: 3] <= rcma_pkg::SRC_MAX;
  assign keyf_set = wr_cfg && cfg_new[rcma_pkg::CFG_KEYF_LSB +: 2] == rcma_pkg::KEYF_LOCREM
                    && keyf != rcma_pkg::KEYF_LOCREM;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rcma_pkg::AXI_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_r <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_r <= 1'b0;
        w_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r == rcma_pkg::RCMA_CFG_OFS || awaddr_r == rcma_pkg::RCMA_IN_OFS
                        || awaddr_r == rcma_pkg::RCMA_CTRL_OFS) ? rcma_pkg::AXI_OKAY : rcma_pkg::AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        // address and data stay refused until the response is taken
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // configuration only changes by explicit write; mode switches never touch it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r  <= rcma_pkg::CFG_RST;
      in_r   <= 32'h0000_0000;
      ctrl_r <= 32'h0000_0000;
    end else if (wr_go) begin
      if (wr_cfg) cfg_r <= cfg_new;
      if (awaddr_r == rcma_pkg::RCMA_IN_OFS) in_r <= wdata_r;
      if (awaddr_r == rcma_pkg::RCMA_CTRL_OFS) ctrl_r <= wdata_r;
    end
  end

  logic [31:0] stat;
  rcma_pkg::rcma_state_t st_r;
  logic armed_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= rcma_pkg::AXI_OKAY;
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rresp <= rcma_pkg::AXI_OKAY;
      unique case (s_axi_araddr)
        rcma_pkg::RCMA_CFG_OFS:  s_axi_rdata <= cfg_r;
        rcma_pkg::RCMA_IN_OFS:   s_axi_rdata <= in_r;
        rcma_pkg::RCMA_STAT_OFS: s_axi_rdata <= stat;
        rcma_pkg::RCMA_CTRL_OFS: s_axi_rdata <= ctrl_r;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= rcma_pkg::AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  assign stat = {22'h0, armed_r, st_r, remote_mode, dir_rev, run_out, search_out, decel_out,
                 set_led, key_f};

  // --------------------------------------------------------------
  // local/remote mode
  // --------------------------------------------------------------
  logic key_press, to_local, to_remote, frst_r, frst_set;
  always_ff @(posedge aclk) begin
    if (!aresetn) key_d_r <= 1'b0;
    else key_d_r <= key_f;
  end
  assign key_press = key_f && !key_d_r;
  // a fault-reset report drops to local once; a later press may still go remote
  assign frst_set  = wr_go && awaddr_r == rcma_pkg::RCMA_CTRL_OFS
                     && wdata_r[rcma_pkg::CTRL_FRST_BIT];
  assign to_local  = (key_press && keyf == rcma_pkg::KEYF_LOCREM && remote_mode) || frst_set;
  assign to_remote = keyf_set
                     || (key_press && keyf == rcma_pkg::KEYF_LOCREM && !remote_mode);

  // fault-reset flag is caught after reset release, not at it
  always_ff @(posedge aclk) begin
    if (!aresetn) frst_r <= 1'b0;
    else if (wr_go && awaddr_r == rcma_pkg::RCMA_CTRL_OFS) frst_r <= wdata_r[rcma_pkg::CTRL_FRST_BIT];
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) remote_mode <= 1'b1;
    else if (to_remote) remote_mode <= 1'b1;
    else if (to_local) remote_mode <= 1'b0;
  end

  logic [BLINK_W-1:0] blink_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_r <= '0;
      set_led <= 1'b0;
    end else begin
      blink_r <= blink_r + 1'b1;
      set_led <= !remote_mode && blink_r[BLINK_W-1];
    end
  end

  // --------------------------------------------------------------
  // command selection
  // --------------------------------------------------------------
  logic term_src, any_term, jog_ok, want_run, want_rev, loc_run, loc_rev;
  assign term_src = src == rcma_pkg::SRC_FWDREV || src == rcma_pkg::SRC_RUNDIR;
  assign any_term = fx_f || rx_f || pex_f;
  assign jog_ok   = |(mfi & en_mask);
  assign loc_run  = in_r[rcma_pkg::IN_RUNKEY_BIT] || (in_r[rcma_pkg::IN_JOG_BIT] && jog_ok);
  assign loc_rev  = in_r[rcma_pkg::IN_REVKEY_BIT];
  always_comb begin
    want_run = 1'b0;
    want_rev = 1'b0;
    if (!remote_mode) begin
      want_run = loc_run && !in_r[rcma_pkg::IN_STOPKEY_BIT];
      want_rev = loc_rev;
    end else if (src == rcma_pkg::SRC_FWDREV) begin
      want_run = fx_f ^ rx_f;   // both on or both off means stop
      want_rev = rx_f;
    end else if (src == rcma_pkg::SRC_RUNDIR) begin
      want_run = fx_f;
      want_rev = rx_f;
    end else if (src == rcma_pkg::SRC_KEYPAD) begin
      want_run = loc_run && !in_r[rcma_pkg::IN_STOPKEY_BIT];
      want_rev = loc_rev;
    end else begin
      want_run = ctrl_r[rcma_pkg::CTRL_COMM_BIT];
      want_rev = ctrl_r[rcma_pkg::CTRL_CDIR_BIT];
    end
  end

  // power-up arm: terminal commands ignored until every one is released, unless power-on run is set with terminal source 1 or 2
  always_ff @(posedge aclk) begin
    if (!aresetn) armed_r <= 1'b0;
    else if (!primed) armed_r <= 1'b0;
    else if (!any_term) armed_r <= 1'b1;
    else if (ponr && term_src && st_r == rcma_pkg::RCMA_STOP && !frst_r) armed_r <= 1'b1;
    else if (to_remote && frst_r) armed_r <= 1'b0;
  end

  // digital sources need a new command after the switch, so drop the held one
  logic need_new_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) need_new_r <= 1'b0;
    else if (to_remote && !term_src) need_new_r <= 1'b1;
    else if (!want_run) need_new_r <= 1'b0;
  end

  logic blocked, go;
  assign blocked = (prev == rcma_pkg::PREV_FWD && !want_rev)
                   || (prev == rcma_pkg::PREV_REV && want_rev);
  assign go = want_run && !blocked && !need_new_r && !(to_remote && !term_src)
              && (!remote_mode || !term_src || armed_r) && !to_local;

  // --------------------------------------------------------------
  // run state
  // --------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) st_r <= rcma_pkg::RCMA_STOP;
    else begin
      unique case (st_r)
        rcma_pkg::RCMA_STOP:   if (go) st_r <= ss_en ? rcma_pkg::RCMA_SEARCH : rcma_pkg::RCMA_RUN;
        rcma_pkg::RCMA_SEARCH: if (!go) st_r <= rcma_pkg::RCMA_STOP;
                               else if (search_done) st_r <= rcma_pkg::RCMA_RUN;
        rcma_pkg::RCMA_RUN:    if (!go && want_run && blocked && loc_rev) st_r <= rcma_pkg::RCMA_DECEL;
                               else if (!go) st_r <= rcma_pkg::RCMA_STOP;
        rcma_pkg::RCMA_DECEL:  if (at_zero_speed) st_r <= rcma_pkg::RCMA_STOP;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_out <= 1'b0;
      search_out <= 1'b0;
      decel_out <= 1'b0;
      dir_rev <= 1'b0;
    end else begin
      run_out <= st_r == rcma_pkg::RCMA_RUN || st_r == rcma_pkg::RCMA_DECEL;
      search_out <= st_r == rcma_pkg::RCMA_SEARCH;
      decel_out <= st_r == rcma_pkg::RCMA_DECEL;
      if (go) dir_rev <= want_rev;
    end
  end
endmodule // rcma_arbiter

// file: test/rcma_arbiter_chk.sv
// Purpose: port checks for rcma_arbiter
// Assumes: one clock, sync active-low reset
// Notes:   bound to every instance, see foot of file
`timescale 1ns/100ps
module rcma_arbiter_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        at_zero_speed,
  input wire logic        set_led,
  input wire logic        remote_mode,
  input wire logic        run_out,
  input wire logic        decel_out,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // the light may trail the mode by a cycle
  a_led_remote: assert property (remote_mode && $past(remote_mode, 2) |-> !set_led)
    else $error("set light lit in remote");
  a_reset_idle: assert property ($rose(aresetn) |-> remote_mode && !run_out && !set_led)
    else $error("outputs not idle after reset");
  a_local_stop: assert property ($fell(remote_mode) |-> ##[0:3] (!run_out || decel_out))
    else $error("output kept driving after local switch");
  a_decel_runs: assert property (decel_out |-> run_out)
    else $error("ramp down without output");
  a_zero_stop: assert property (decel_out && at_zero_speed |-> ##[1:3] !decel_out)
    else $error("ramp down not ended at zero speed");
  a_one_toggle: assert property ($changed(remote_mode) |=> $stable(remote_mode)[*4])
    else $error("mode changed twice for one press");
  a_w_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_r_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == rcma_pkg::AXI_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read with nonzero data");
endmodule // rcma_arbiter_chk

bind rcma_arbiter rcma_arbiter_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .at_zero_speed(at_zero_speed), .set_led(set_led),
  .remote_mode(remote_mode), .run_out(run_out), .decel_out(decel_out), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata)
);

// file: test/rcma_pad.sv
// Purpose: keypad key and ramp stand-in for the arbiter
// Assumes: same clock as the arbiter
// Notes:   DLY sets how slowly the ramp answers
`timescale 1ns/100ps
module rcma_pad #(
  parameter int DLY = 3
) (
  input  wire logic aclk,
  input  wire logic key_req,
  input  wire logic decel_out,
  input  wire logic search_out,
  output logic      mode_toggle_key,
  output logic      at_zero_speed,
  output logic      search_done
);
  // ----------------------------------------------------------------
  // key press and ramp answers
  // ----------------------------------------------------------------
  logic [3:0] key_r = 4'h0;
  logic [7:0] dz_r  = 8'h00;
  logic [7:0] ds_r  = 8'h00;
  // a press is held well past the input filter so it is one clean edge
  always_ff @(posedge aclk) begin
    if (key_req) key_r <= 4'h8;
    else if (key_r != 4'h0) key_r <= key_r - 4'h1;
  end
  always_ff @(posedge aclk) dz_r <= decel_out ? dz_r + 8'h01 : 8'h00;
  always_ff @(posedge aclk) ds_r <= search_out ? ds_r + 8'h01 : 8'h00;
  assign mode_toggle_key = key_r != 4'h0;
  assign at_zero_speed   = dz_r >= 8'(DLY);
  assign search_done     = ds_r >= 8'(DLY);
endmodule // rcma_pad

// file: test/rcma_arbiter_tb.sv
// Purpose: self-checking bench for rcma_arbiter
// Assumes: 40 MHz clock, AXI4-Lite master in this module
// Notes:   register rows first, then mode and start cases
`timescale 1ns/100ps
module rcma_arbiter_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG = rcma_pkg::RCMA_CFG_OFS, INR = rcma_pkg::RCMA_IN_OFS, CTL = rcma_pkg::RCMA_CTRL_OFS;
  localparam logic [1:0] OK = rcma_pkg::AXI_OKAY, ER = rcma_pkg::AXI_SLVERR;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} rcma_row_t;
  logic        aclk, key, azs, sdone, set_led, remote_mode, run_out, dir_rev, search_out, decel_out;
  logic        aresetn = 1'b0, key_req = 1'b0, fwd = 1'b0, rev = 1'b0, pex = 1'b0;
  logic [6:0]  mfi = 7'h00;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [5:0]  o;
  int          failures = 0, n_tests = 0;
  rcma_row_t   rows [4] = '{'{CFG, 32'h7f10_1201, 32'h7f10_1201, OK}, '{CFG, 32'h6, 32'h7f10_1201, OK},
                            '{8'h10, 32'h5, 32'h0, ER}, '{CTL, 32'h0, 32'h0, OK}};
  assign o = {set_led, dir_rev, decel_out, search_out, remote_mode, run_out};
  rcma_arbiter #(.N_IN(7), .BLINK_W(4)) DUT (
    .aclk(aclk), .aresetn(aresetn), .mode_toggle_key(key), .multi_function_inputs(mfi),
    .forward_run_input(fwd), .reverse_run_input(rev), .preexcite_input(pex), .at_zero_speed(azs),
    .search_done(sdone), .set_led(set_led), .remote_mode(remote_mode), .run_out(run_out), .dir_rev(dir_rev),
    .search_out(search_out), .decel_out(decel_out), .s_axi_awaddr(addr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(addr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  rcma_pad #(.DLY(3)) u_pad (
    .aclk(aclk), .key_req(key_req), .decel_out(decel_out), .search_out(search_out),
    .mode_toggle_key(key), .at_zero_speed(azs), .search_done(sdone)
  );
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // a spent bound ends the run rather than hanging it
  task tmo(input int i);
    if (i >= 300) begin
      failures++;
      test_done;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    addr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    for (i = 0; i < 300 && !bvalid; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    r = bresp;
    bready <= 1'b0;
    tmo(i);
  endtask
  task rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    addr <= a;
    {arvalid, rready} <= 2'b11;
    for (i = 0; i < 300 && !rvalid; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    q = rdata;
    r = rresp;
    rready <= 1'b0;
    tmo(i);
  endtask
  task wfor(input string n, input int s, input logic v);
    int i;
    for (i = 0; i < 300 && o[s] !== v; i++) @(posedge aclk);
    tmo(i);
    chk(n, v, o[s]);
  endtask
  task press;
    @(posedge aclk);
    key_req <= 1'b1;
    @(posedge aclk);
    key_req <= 1'b0;
    repeat (30) @(posedge aclk);
  endtask
  task rst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    rst;
    rd(CFG);
    chk("cfg reset", rcma_pkg::CFG_RST, q);
    chk("remote reset", 1, remote_mode);
    for (int k = 0; k < 4; k++) begin
      wr(rows[k].a, rows[k].d);
      chk("bresp", rows[k].r, r);
      rd(rows[k].a);
      chk("rdata", rows[k].q, q);
      chk("rresp", rows[k].r, r);
    end
    fwd <= 1'b1;
    rst;
    wr(CFG, 32'h1);
    repeat (20) @(posedge aclk);
    chk("no power-on start", 0, run_out);
    fwd <= 1'b0;
    repeat (10) @(posedge aclk);
    fwd <= 1'b1;
    wfor("run after re-press", 0, 1);
    chk("forward", 0, dir_rev);
    rev <= 1'b1;
    wfor("both on stops", 0, 0);
    fwd <= 1'b0;
    wfor("reverse dir", 4, 1);
    wfor("reverse runs", 0, 1);
    rev <= 1'b0;
    fwd <= 1'b1;
    rst;
    wr(CFG, 32'h1001);
    wfor("power-on run", 0, 1);
    wr(CFG, 32'h1002);
    rev <= 1'b1;
    wfor("direction input", 4, 1);
    chk("still running", 1, run_out);
    press;
    chk("key ignored", 1, remote_mode);
    wr(CFG, 32'h1022);
    press;
    chk("local", 0, remote_mode);
    wfor("set light flashes", 5, 1);
    wfor("local stops", 0, 0);
    wr(CFG, 32'h1002);
    wr(CFG, 32'h1022);
    wfor("forced remote", 1, 1);
    wfor("terminal keeps run", 0, 1);
    chk("reverse kept", 1, dir_rev);
    rd(CFG);
    chk("cfg kept", 32'h1022, q);
    press;
    fwd <= 1'b0;
    rev <= 1'b0;
    wfor("local stops", 0, 0);
    wr(CFG, 32'h1222);
    wr(INR, 32'h1);
    wfor("keypad run", 0, 1);
    wr(INR, 32'h5);
    wfor("blocked reverse", 3, 1);
    wfor("ramped to stop", 0, 0);
    wr(INR, 32'h0);
    wr(CFG, 32'h0100_0020);
    wr(INR, 32'h8);
    repeat (20) @(posedge aclk);
    chk("jog without enable", 0, run_out);
    mfi <= 7'h01;
    wfor("jog with enable", 0, 1);
    mfi <= 7'h00;
    wfor("jog dropped", 0, 0);
    wr(INR, 32'h1);
    wfor("keypad run", 0, 1);
    press;
    chk("remote", 1, remote_mode);
    chk("light off", 0, set_led);
    wfor("keypad source stops", 0, 0);
    repeat (20) @(posedge aclk);
    chk("held run key ignored", 0, run_out);
    wr(INR, 32'h0);
    wr(INR, 32'h1);
    wfor("next run command", 0, 1);
    wr(INR, 32'h0);
    wfor("keypad stop", 0, 0);
    wr(CFG, 32'h0010_1021);
    fwd <= 1'b1;
    wfor("search first", 2, 1);
    wfor("run after search", 0, 1);
    wr(CTL, 32'h1);
    wfor("fault gives local", 1, 0);
    press;
    repeat (40) @(posedge aclk);
    chk("held off", 0, run_out);
    fwd <= 1'b0;
    repeat (10) @(posedge aclk);
    fwd <= 1'b1;
    wfor("run after release", 0, 1);
    test_done;
  end
endmodule // rcma_arbiter_tb
